//--- cld_byte_port.sv
// Purpose: byte holding register and read request flag toward the host
// Assumes: load and clear are single-cycle pulses
// Notes:   a host clear in the same cycle as a new byte lets the byte in
`timescale 1ns/10ps
`default_nettype none
module cld_byte_port
    import cld_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [7:0] byte_in,
    input  wire logic       clr,
    output var  logic [7:0] data,
    output var  logic       rdreq,
    output var  logic       overrun,
    output var  logic       taken
);

    cld_port_s_t s_q;
    cld_port_s_t s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d         = s_q;
        s_d.overrun = 1'b0;
        s_d.taken   = 1'b0;
        if (clr) begin
            // R8 host clears request
            s_d.rdreq = 1'b0;
        end
        if (load) begin
            if (s_q.rdreq && !clr) begin
                // R9 previous byte unread
                s_d.overrun = 1'b1;
            end else begin
                // R13 byte on data bits
                s_d.data  = byte_in;
                // R7 raise read request
                s_d.rdreq = 1'b1;
                s_d.taken = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{data: CLD_BYTE_RST, rdreq: 1'b0, overrun: 1'b0, taken: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign data    = s_q.data;
    assign rdreq   = s_q.rdreq;
    assign overrun = s_q.overrun;
    assign taken   = s_q.taken;

    ////////////////////////////////////////////////////////////////////////
    AST_BYTE_BEFORE_REQ: assert property (@(posedge clk) disable iff (rst) // R13
        (load && (!rdreq || clr)) |=> (rdreq && data == $past(byte_in)))
        else $error("byte not presented with read request");

    AST_REQ_HOLDS: assert property (@(posedge clk) disable iff (rst) // R7
        (rdreq && !clr) |=> rdreq)
        else $error("read request dropped without host clear");

    AST_OVERRUN_KEEPS: assert property (@(posedge clk) disable iff (rst) // R9
        (load && rdreq && !clr) |=> (overrun && data == $past(data)))
        else $error("overrun not flagged or data overwritten");

endmodule
`default_nettype wire

//--- cld_host_model.sv
// Purpose: host computer side of the panel link, loader firmware behaviour
// Assumes: outputs change just after CLK; untouched by the unit's own reset
// Notes:   slow adds wait states per byte; stall withholds the clear
`timescale 1ns/10ps
`default_nettype none
module cld_host_model #(
    parameter logic SELFTEST_OK = 1'h1
) (
    input  wire logic       clk,
    input  wire logic       halt_req,
    input  wire logic       load_req,
    input  wire logic       rdreq,
    input  wire logic [7:0] data,
    input  wire logic       slow,
    input  wire logic       stall,
    input  wire logic       eof_cmd,
    output var  logic       run_n,
    output var  logic       clr_rdreq,
    output var  logic       clr_wrreq,
    output var  logic       got,
    output var  logic [7:0] got_byte
);
    logic       wait_lo;
    logic [2:0] cnt;
    logic [2:0] lcnt;

    initial begin
        {run_n, clr_rdreq, clr_wrreq, got, wait_lo} = 5'h0;
        {got_byte, cnt, lcnt} = 14'h0;
    end

    always @(posedge clk) begin
        clr_rdreq <= 1'h0;
        got       <= 1'h0;
        if (halt_req) begin
            run_n <= 1'h1;
        end else if (load_req && run_n && SELFTEST_OK) begin
            lcnt <= lcnt + 3'h1;
            if (lcnt == 3'h4) begin
                run_n <= 1'h0;
                lcnt  <= 3'h0;
            end
        end
        clr_wrreq <= eof_cmd;
        if (wait_lo) begin
            wait_lo <= rdreq;
        end else if (rdreq && !stall) begin
            if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end else begin
                clr_rdreq <= 1'h1;
                got       <= 1'h1;
                got_byte  <= data;
                wait_lo   <= 1'h1;
                cnt       <= slow ? 3'h5 : 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

//--- cld_pkg.sv
// Purpose: constants and types for the cassette load handshake controller
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes:   registers are reached over APB, one aligned 32-bit word each
//
// Behaviour
// R1: rewind stops by itself at clear leader
// R2: unlocked halt press halts run, panel halts
// R3: host treats load plus present as load
// R4: failed self-test lights fault, skips load; host model skips load, lights no fault
// R5: passing self-test branches loader, keeps base
// R6: no tape bytes before run goes active
// R7: ready byte sets read request bit 12
// R8: host shifts byte, then clears bit 12
// R9: new byte while bit 12 set aborts
// R10: clear-write-request bit 13 stops tape, idles
// R11: local reset touches only this controller
// R12: run active ignores all but halt switch
// R13: byte presented on eight fixed-order bits first
package cld_pkg;

    localparam logic [7:0] CLD_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CLD_OFF_STATUS = 8'h04;
    localparam logic [7:0] CLD_OFF_ISTAT  = 8'h08;
    localparam logic [7:0] CLD_OFF_IMASK  = 8'h0C;
    localparam logic [7:0] CLD_OFF_COUNT  = 8'h10;

    // control register bits (write one to act)
    localparam int CLD_CTRL_REWIND = 0;
    localparam int CLD_CTRL_LOAD   = 1;
    localparam int CLD_CTRL_FCLR   = 2;

    // event bits, shared by status-of-interrupt and mask registers
    localparam int CLD_EV_LEADER  = 0;
    localparam int CLD_EV_BYTE    = 1;
    localparam int CLD_EV_OVERRUN = 2;
    localparam int CLD_EV_EOF     = 3;
    localparam int CLD_EV_W       = 4;

    localparam logic [CLD_EV_W-1:0] CLD_IMASK_RST = 4'h0;
    localparam logic [15:0]         CLD_COUNT_RST = 16'h0000;
    localparam logic [7:0]          CLD_BYTE_RST  = 8'h00;

    typedef enum logic [2:0] {
        CLD_IDLE,
        CLD_REWIND,
        CLD_WAIT_RUN,
        CLD_STREAM,
        CLD_ABORT
    } cld_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       rdreq;
        logic       overrun;
        logic       taken;
    } cld_port_s_t;

    typedef struct packed {
        cld_state_t          st;
        logic                motor;
        logic                reverse;
        logic                halt_req;
        logic                load_req;
        logic                fault;
        logic                run_led;
        logic                halt_sw;
        logic                load_sw;
        logic                rew_sw;
        logic [CLD_EV_W-1:0] ist;
        logic [CLD_EV_W-1:0] imask;
        logic                irq;
        logic [15:0]         count;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } cld_top_s_t;

endpackage

//--- cld_top.sv
// Purpose: maintenance unit tape load controller with APB register access
// Assumes: panel, tape and host inputs are synchronous to CLK
// Notes:   APB answers with no wait states; PSLVERR on unmapped offsets
`timescale 1ns/10ps
`default_nettype none
module cld_top
    import cld_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic [7:0]  TAPE_BYTE,
    input  wire logic        TAPE_VALID,
    input  wire logic        TAPE_LEADER,
    output var  logic        TAPE_MOTOR,
    output var  logic        TAPE_REVERSE,
    input  wire logic        REWIND_SW,
    input  wire logic        LOAD_SW,
    input  wire logic        HALT_SW,
    input  wire logic        KEY_UNLOCK,
    input  wire logic        RUN_N,
    output var  logic        RUN_LED,
    output var  logic        HALT_REQ,
    output var  logic        LOAD_REQ,
    output var  logic        FAULT_LED,
    output var  logic [7:0]  IF_DATA,
    output var  logic        IF_RDREQ,
    input  wire logic        HOST_CLR_RDREQ,
    input  wire logic        HOST_CLR_WRREQ,
    output var  logic        IRQ
);

    cld_top_s_t          s_q;
    cld_top_s_t          s_d;
    logic                run_act;
    logic                halt_press;
    logic                load_press;
    logic                rew_press;
    logic                setup_rd;
    logic                acc_wr;
    logic                acc_rd;
    logic                addr_ok;
    logic                byte_load;
    logic                eof;
    logic                overrun;
    logic                taken;
    logic [CLD_EV_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////
    // byte port toward the host
    cld_byte_port u_port (
        .clk     (CLK),
        .rst     (SYS_RST),
        .load    (byte_load),
        .byte_in (TAPE_BYTE),
        .clr     (HOST_CLR_RDREQ),
        .data    (IF_DATA),
        .rdreq   (IF_RDREQ),
        .overrun (overrun),
        .taken   (taken)
    );

    ////////////////////////////////////////////////////////////////////////
    // switch edges and bus decode
    always_comb begin
        run_act    = !RUN_N;
        halt_press = HALT_SW && !s_q.halt_sw && KEY_UNLOCK;
        load_press = LOAD_SW && !s_q.load_sw;
        rew_press  = REWIND_SW && !s_q.rew_sw;
        addr_ok    = (PADDR == CLD_OFF_CTRL) || (PADDR == CLD_OFF_STATUS) ||
                     (PADDR == CLD_OFF_ISTAT) || (PADDR == CLD_OFF_IMASK) ||
                     (PADDR == CLD_OFF_COUNT);
        setup_rd   = PSEL && !PENABLE && !PWRITE;
        acc_wr     = PSEL && PENABLE && PWRITE;
        acc_rd     = PSEL && PENABLE && !PWRITE;
        eof        = (s_q.st == CLD_STREAM) && HOST_CLR_WRREQ;
        // R6 bytes only while streaming
        byte_load  = (s_q.st == CLD_STREAM) && TAPE_VALID && !HOST_CLR_WRREQ;
        ev         = '0;
        ev[CLD_EV_LEADER]  = (s_q.st == CLD_REWIND) && TAPE_LEADER;
        ev[CLD_EV_BYTE]    = taken;
        ev[CLD_EV_OVERRUN] = overrun;
        ev[CLD_EV_EOF]     = eof;
    end

    ////////////////////////////////////////////////////////////////////////
    // controller state
    always_comb begin
        s_d          = s_q;
        s_d.halt_sw  = HALT_SW;
        s_d.load_sw  = LOAD_SW;
        s_d.rew_sw   = REWIND_SW;
        s_d.run_led  = run_act;
        // R2 unlocked halt press
        s_d.halt_req = run_act && halt_press;
        unique case (s_q.st)
            CLD_IDLE: begin
                // R12 run active masks switches
                if (!run_act && (rew_press || (acc_wr && PADDR == CLD_OFF_CTRL &&
                                               PWDATA[CLD_CTRL_REWIND]))) begin
                    s_d.st      = CLD_REWIND;
                    s_d.motor   = 1'b1;
                    s_d.reverse = 1'b1;
                end else if (!run_act && (load_press || (acc_wr && PADDR == CLD_OFF_CTRL &&
                                                         PWDATA[CLD_CTRL_LOAD]))) begin
                    s_d.st       = CLD_WAIT_RUN;
                    s_d.load_req = 1'b1;
                    s_d.count    = CLD_COUNT_RST;
                end
            end
            CLD_REWIND: begin
                // R1 stop at clear leader
                if (TAPE_LEADER) begin
                    s_d.st      = CLD_IDLE;
                    s_d.motor   = 1'b0;
                    s_d.reverse = 1'b0;
                end
            end
            CLD_WAIT_RUN: begin
                // R6 wait for run
                if (run_act) begin
                    s_d.st       = CLD_STREAM;
                    s_d.load_req = 1'b0;
                    s_d.motor    = 1'b1;
                    s_d.reverse  = 1'b0;
                end
            end
            CLD_STREAM: begin
                if (taken) begin
                    s_d.count = s_q.count + 16'h0001;
                end
                if (eof) begin
                    // R10 end of file stops tape
                    s_d.st    = CLD_IDLE;
                    s_d.motor = 1'b0;
                end else if (overrun) begin
                    // R9 abort and fault
                    s_d.st    = CLD_ABORT;
                    s_d.motor = 1'b0;
                    s_d.fault = 1'b1;
                end
            end
            CLD_ABORT: begin
                if (acc_wr && PADDR == CLD_OFF_CTRL && PWDATA[CLD_CTRL_FCLR]) begin
                    s_d.st    = CLD_IDLE;
                    s_d.fault = 1'b0;
                end
            end
        endcase

        // bus slave, zero wait states
        s_d.pready  = 1'b1;
        s_d.pslverr = PSEL && !PENABLE && !addr_ok;
        if (acc_wr && PADDR == CLD_OFF_IMASK) begin
            s_d.imask = PWDATA[CLD_EV_W-1:0];
        end
        if (setup_rd) begin
            s_d.prdata = 32'h0000_0000;
            unique case (PADDR)
                CLD_OFF_STATUS: s_d.prdata[8:0] = {s_q.count[0], IF_RDREQ, run_act,
                                                   s_q.fault, s_q.motor, 1'b0, s_q.st};
                CLD_OFF_ISTAT:  s_d.prdata[CLD_EV_W-1:0] = s_q.ist;
                CLD_OFF_IMASK:  s_d.prdata[CLD_EV_W-1:0] = s_q.imask;
                CLD_OFF_COUNT:  s_d.prdata[15:0] = s_q.count;
                default:        s_d.prdata = 32'h0000_0000;
            endcase
        end
        // read clears only the bits returned; new events win
        s_d.ist = s_q.ist | ev;
        if (acc_rd && PADDR == CLD_OFF_ISTAT) begin
            s_d.ist = (s_q.ist & ~s_q.prdata[CLD_EV_W-1:0]) | ev;
        end
        s_d.irq = |(s_q.ist & s_q.imask);
    end

    // R11 local reset only
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_q       <= '0;
            s_q.st    <= CLD_IDLE;
            s_q.imask <= CLD_IMASK_RST;
            s_q.count <= CLD_COUNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA       = s_q.prdata;
    assign PREADY       = s_q.pready;
    assign PSLVERR      = s_q.pslverr;
    assign TAPE_MOTOR   = s_q.motor;
    assign TAPE_REVERSE = s_q.reverse;
    assign RUN_LED      = s_q.run_led;
    assign HALT_REQ     = s_q.halt_req;
    assign LOAD_REQ     = s_q.load_req;
    assign FAULT_LED    = s_q.fault;
    assign IRQ          = s_q.irq;

    ////////////////////////////////////////////////////////////////////////
    AST_LEADER_STOP: assert property (@(posedge CLK) disable iff (SYS_RST) // R1
        (s_q.st == CLD_REWIND && TAPE_LEADER) |=> (!TAPE_MOTOR && s_q.st == CLD_IDLE))
        else $error("rewind did not stop at leader");

    AST_HALT_PRESS: assert property (@(posedge CLK) disable iff (SYS_RST) // R2
        (!RUN_N && KEY_UNLOCK && HALT_SW && !$past(HALT_SW)) |=> HALT_REQ)
        else $error("unlocked halt press not passed on");

    AST_NO_EARLY_BYTE: assert property (@(posedge CLK) disable iff (SYS_RST) // R6
        (s_q.st != CLD_STREAM) |=> !taken)
        else $error("byte sent before run became active");

    AST_RUN_GO: assert property (@(posedge CLK) disable iff (SYS_RST) // R6
        (s_q.st == CLD_WAIT_RUN && !RUN_N) |=> (s_q.st == CLD_STREAM && TAPE_MOTOR && !LOAD_REQ))
        else $error("stream did not start on run");

    AST_OVERRUN_ABORT: assert property (@(posedge CLK) disable iff (SYS_RST) // R9
        overrun && s_q.st == CLD_STREAM && !HOST_CLR_WRREQ |=> (FAULT_LED && !TAPE_MOTOR))
        else $error("overrun did not abort load");

    AST_EOF_IDLE: assert property (@(posedge CLK) disable iff (SYS_RST) // R10
        eof |=> (s_q.st == CLD_IDLE && !TAPE_MOTOR) ##1 !TAPE_MOTOR)
        else $error("clear write request did not stop tape");

    AST_LOCAL_RESET: assert property (@(posedge CLK) // R11
        SYS_RST |=> (s_q.st == CLD_IDLE && !FAULT_LED && !HALT_REQ && !TAPE_MOTOR))
        else $error("local reset did not clear controller");

    AST_RUN_MASK: assert property (@(posedge CLK) disable iff (SYS_RST) // R12
        (!RUN_N && s_q.st == CLD_IDLE) |=> !(s_q.st inside {CLD_REWIND, CLD_WAIT_RUN}))
        else $error("switch acted while run active");

endmodule
`default_nettype wire

//--- test_cld_top.sv
// Purpose: self-checking bench for the tape load controller
// Assumes: host model on the panel link, APB master here
// Notes:   byte notes queued by the driver, checked as the host takes them
`timescale 1ns/10ps
`default_nettype none
module test_cld_top;
    import cld_pkg::*;
    logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0]  PADDR, TAPE_BYTE, IF_DATA, got_byte, b;
    logic [31:0] PWDATA, PRDATA, rd;
    logic        TAPE_VALID, TAPE_LEADER, TAPE_MOTOR, TAPE_REVERSE, REWIND_SW, LOAD_SW, HALT_SW;
    logic        KEY_UNLOCK, RUN_N, RUN_LED, HALT_REQ, LOAD_REQ, FAULT_LED, IF_RDREQ;
    logic        HOST_CLR_RDREQ, HOST_CLR_WRREQ, IRQ, slow, stall, eof_cmd, got, err;
    logic [7:0]  exp_q[$];
    int          bad_count, cmp_count, seed, k, halt_cnt;

    cld_top i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TAPE_BYTE(TAPE_BYTE), .TAPE_VALID(TAPE_VALID), .TAPE_LEADER(TAPE_LEADER),
        .TAPE_MOTOR(TAPE_MOTOR), .TAPE_REVERSE(TAPE_REVERSE), .REWIND_SW(REWIND_SW),
        .LOAD_SW(LOAD_SW), .HALT_SW(HALT_SW), .KEY_UNLOCK(KEY_UNLOCK), .RUN_N(RUN_N),
        .RUN_LED(RUN_LED), .HALT_REQ(HALT_REQ), .LOAD_REQ(LOAD_REQ), .FAULT_LED(FAULT_LED),
        .IF_DATA(IF_DATA), .IF_RDREQ(IF_RDREQ), .HOST_CLR_RDREQ(HOST_CLR_RDREQ),
        .HOST_CLR_WRREQ(HOST_CLR_WRREQ), .IRQ(IRQ));
    cld_host_model i_host (.clk(CLK), .halt_req(HALT_REQ), .load_req(LOAD_REQ), .rdreq(IF_RDREQ),
        .data(IF_DATA), .slow(slow), .stall(stall), .eof_cmd(eof_cmd), .run_n(RUN_N),
        .clr_rdreq(HOST_CLR_RDREQ), .clr_wrreq(HOST_CLR_WRREQ), .got(got), .got_byte(got_byte));

    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end

    ////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: sig = IF_RDREQ;
            1: sig = TAPE_MOTOR;
            2: sig = LOAD_REQ;
            3: sig = IRQ;
            default: sig = FAULT_LED;
        endcase
    endfunction
    task automatic wait_for(input int s, input logic v);
        int i;
        for (i = 0; i < 200 && sig(s) !== v; i++) tick(1);
        if (i == 200) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge CLK);
        PSEL <= 1'h1; PENABLE <= 1'h0; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge CLK);
            if (PREADY === 1'h1) break;
        end
        if (i == 50) begin
            bad_count++;
            final_report();
        end else begin
            rd = PRDATA;
            err = PSLVERR;
            PSEL <= 1'h0; PENABLE <= 1'h0;
            #1;
        end
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, exp, rd & m);
    endtask
    task automatic press(input int w);
        @(posedge CLK);
        case (w)
            0: REWIND_SW <= 1'h1;
            1: LOAD_SW <= 1'h1;
            default: HALT_SW <= 1'h1;
        endcase
        repeat (2) @(posedge CLK);
        REWIND_SW <= 1'h0; LOAD_SW <= 1'h0; HALT_SW <= 1'h0;
        #1;
    endtask
    task automatic send(input logic [7:0] v, input logic taken);
        @(posedge CLK);
        TAPE_BYTE <= v; TAPE_VALID <= 1'h1;
        if (taken) exp_q.push_back(v);
        @(posedge CLK);
        TAPE_VALID <= 1'h0; TAPE_BYTE <= ~v;
        #1;
    endtask
    task automatic do_load(input logic by_sw);
        if (by_sw) press(1);
        else apb(1'h1, CLD_OFF_CTRL, 32'h1 << CLD_CTRL_LOAD);
        wait_for(2, 1'h1);
        chk("motor_before_run", 1'h0, TAPE_MOTOR);
        wait_for(1, 1'h1);
        chk("run_n", 1'h0, RUN_N);
        chk("reverse", 1'h0, TAPE_REVERSE);
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge CLK) begin
        if (HALT_REQ === 1'h1) halt_cnt++;
        if (got === 1'h1) begin
            if (exp_q.size() == 0) chk("byte_extra", 32'h0, 32'h1);
            else chk("byte", exp_q.pop_front(), got_byte);
        end
    end

    initial begin
        seed = 10545;
        {SYS_RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'h1, 43'h0};
        {TAPE_BYTE, TAPE_VALID, TAPE_LEADER, REWIND_SW, LOAD_SW, HALT_SW, KEY_UNLOCK} = 14'h0;
        {slow, stall, eof_cmd} = 3'h0;
        repeat (6) @(posedge CLK);
        SYS_RST <= 1'h0;
        #1;
        rreg(CLD_OFF_IMASK, 32'h0, 32'hF, "imask");
        rreg(CLD_OFF_COUNT, 32'h0, 32'hFFFF, "count");
        rreg(8'h14, 32'h0, 32'hFFFFFFFF, "unmapped");
        chk("slverr", 1'h1, err);
        $display("test reset done");
        press(1);
        press(2);
        tick(4);
        chk("load_ignored", 1'h0, LOAD_REQ);
        chk("run_led", 1'h1, RUN_LED);
        chk("locked_halt", 32'h0, halt_cnt);
        @(posedge CLK) KEY_UNLOCK <= 1'h1;
        press(2);
        tick(3);
        chk("halt_pulse", 32'h1, halt_cnt);
        chk("halted_led", 1'h0, RUN_LED);
        $display("test halt done");
        apb(1'h1, CLD_OFF_IMASK, 32'h1);
        press(0);
        tick(1);
        chk("rew_motor", 1'h1, TAPE_MOTOR);
        chk("rew_reverse", 1'h1, TAPE_REVERSE);
        @(posedge CLK) TAPE_LEADER <= 1'h1;
        tick(2);
        chk("leader_motor", 1'h0, TAPE_MOTOR);
        chk("leader_reverse", 1'h0, TAPE_REVERSE);
        @(posedge CLK) TAPE_LEADER <= 1'h0;
        wait_for(3, 1'h1);
        rreg(CLD_OFF_ISTAT, 32'h1, 32'hF, "istat_leader");
        tick(2);
        chk("irq_cleared", 1'h0, IRQ);
        $display("test rewind done");
        do_load(1'h1);
        for (k = 0; k < 6; k++) begin
            @(posedge CLK) slow <= k[0];
            b = 8'($random(seed));
            send(b, 1'h1);
            chk("rdreq", 1'h1, IF_RDREQ);
            chk("if_data", b, IF_DATA);
            wait_for(0, 1'h0);
        end
        @(posedge CLK) eof_cmd <= 1'h1;
        @(posedge CLK) eof_cmd <= 1'h0;
        tick(3);
        chk("eof_motor", 1'h0, TAPE_MOTOR);
        rreg(CLD_OFF_STATUS, 32'h0, 32'h7, "eof_idle");
        rreg(CLD_OFF_COUNT, 32'h6, 32'hFFFF, "count");
        rreg(CLD_OFF_ISTAT, 32'hA, 32'hF, "istat_stream");
        chk("irq_masked", 1'h0, IRQ);
        chk("queue_empty", 32'h0, exp_q.size());
        $display("test stream done");
        press(2);
        tick(3);
        chk("halt_again", 32'h2, halt_cnt);
        stall <= 1'h1;
        do_load(1'h0);
        send(8'h5A, 1'h0);
        send(8'hA5, 1'h0);
        wait_for(4, 1'h1);
        tick(1);
        chk("abort_motor", 1'h0, TAPE_MOTOR);
        rreg(CLD_OFF_STATUS, 32'h4, 32'h7, "abort_state");
        rreg(CLD_OFF_ISTAT, 32'h4, 32'h4, "istat_overrun");
        apb(1'h1, CLD_OFF_CTRL, 32'h1 << CLD_CTRL_FCLR);
        chk("fault_cleared", 1'h0, FAULT_LED);
        rreg(CLD_OFF_STATUS, 32'h0, 32'h7, "abort_left");
        $display("test overrun done");
        @(posedge CLK) SYS_RST <= 1'h1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'h0;
        #1;
        chk("rst_rdreq", 1'h0, IF_RDREQ);
        chk("rst_host_run", 1'h0, RUN_N);
        rreg(CLD_OFF_COUNT, 32'h0, 32'hFFFF, "rst_count");
        $display("test local reset done");
        final_report();
    end
endmodule
`default_nettype wire
